// ---- src/mcr_pkg.sv ----
// Register map, reset values and carrier types of the calibration bank
package mcr_pkg;

  localparam logic [6:0] ADDR_IRMS_OS_C    = 7'h38;
  localparam logic [6:0] ADDR_ACT_OS_A     = 7'h39;
  localparam logic [6:0] ADDR_ACT_OS_B     = 7'h3A;
  localparam logic [6:0] ADDR_ACT_OS_C     = 7'h3B;
  localparam logic [6:0] ADDR_REACT_OS_A   = 7'h3C;
  localparam logic [6:0] ADDR_REACT_OS_B   = 7'h3D;
  localparam logic [6:0] ADDR_REACT_OS_C   = 7'h3E;
  localparam logic [6:0] ADDR_TRIM_A       = 7'h3F;
  localparam logic [6:0] ADDR_TRIM_B       = 7'h40;
  localparam logic [6:0] ADDR_TRIM_C       = 7'h41;
  localparam logic [6:0] ADDR_ACT_DIV      = 7'h42;
  localparam logic [6:0] ADDR_REACT_DIV    = 7'h43;
  localparam logic [6:0] ADDR_APP_DIV      = 7'h44;
  localparam logic [6:0] ADDR_ACT_NUM      = 7'h45;
  localparam logic [6:0] ADDR_ACT_DEN      = 7'h46;
  localparam logic [6:0] ADDR_REACT_NUM    = 7'h47;
  localparam logic [6:0] ADDR_REACT_DEN    = 7'h48;
  localparam logic [6:0] ADDR_ONES_COUNT   = 7'h7E;
  localparam logic [6:0] ADDR_DIE_REVISION = 7'h7F;

  localparam logic [11:0] OFFSET_RST = 12'h000;
  localparam logic [6:0]  TRIM_RST   = 7'h00;
  localparam logic [7:0]  DIV_RST    = 8'h00;
  localparam logic [12:0] NUM_RST    = 13'h0000;
  localparam logic [11:0] DEN_RST    = 12'h03F;
  localparam logic [7:0]  ONES_RST   = 8'h00;

  // Numerator bits 15:13 carry the reverse flags, A at the top
  localparam int REV_FLAG_LSB = 13;
  // Command byte: bit 7 selects write, bits 6:0 the address
  localparam int CMD_WRITE_BIT = 7;
  localparam logic [4:0] CMD_BITS  = 5'h08;
  localparam logic [4:0] END_SHORT = 5'h10;
  localparam logic [4:0] END_LONG  = 5'h18;

  typedef enum logic [1:0] {
    MCR_CMD,
    MCR_LOAD,
    MCR_DATA,
    MCR_DONE
  } mcr_phase_t;

  // Index 0 is phase A
  typedef struct packed {
    logic [11:0]      irms_os_c;
    logic [2:0][11:0] active_os;
    logic [2:0][11:0] reactive_os;
    logic [2:0][6:0]  phase_trim;
    logic [7:0]       active_div;
    logic [7:0]       reactive_div;
    logic [7:0]       apparent_div;
    logic [12:0]      active_num;
    logic [11:0]      active_den;
    logic [12:0]      reactive_num;
    logic [11:0]      reactive_den;
  } mcr_cal_t;

  typedef struct packed {
    logic        cmd_valid;
    logic        write;
    logic [6:0]  addr;
    logic        wr_valid;
    logic [15:0] wr_data;
  } mcr_spi_req_t;

  // Bit count at which a transfer to this address ends
  function automatic logic [4:0] mcr_end_count(input logic [6:0] a);
    logic wide;
    wide = (a >= ADDR_IRMS_OS_C && a <= ADDR_REACT_OS_C) ||
           (a >= ADDR_ACT_NUM && a <= ADDR_REACT_DEN);
    return wide ? END_LONG : END_SHORT;
  endfunction

endpackage

// ---- src/mcr_ones_count.sv ----
// Count of one bits in a read word
`timescale 1ns/1ps
module mcr_ones_count #(
  parameter int W = 16
) (
  input  wire logic [W-1:0] value,
  output logic      [7:0]   count
);
  always_comb begin
    count = 8'h00;
    for (int i = 0; i < W; i++) begin
      count = count + 8'(value[i]);
    end
  end
endmodule

// ---- src/mcr_spi_port.sv ----
// Serial port engine: pin synchronisers, command and data shifting
`timescale 1ns/1ps
module mcr_spi_port
  import mcr_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         spi_sclk,
  input  wire logic         spi_din,
  input  wire logic         spi_cs_n,
  input  wire logic [15:0]  rd_data,
  output logic              spi_dout,
  output logic              spi_dout_oe,
  output mcr_spi_req_t      req
);
  typedef struct packed {
    logic         sclk_s1;
    logic         sclk_s2;
    logic         sclk_d;
    logic         din_s1;
    logic         din_s2;
    logic         cs_s1;
    logic         cs_s2;
    mcr_phase_t   phase;
    logic [4:0]   cnt;
    logic [4:0]   last;
    logic [15:0]  in_sh;
    logic [15:0]  out_sh;
    logic         dout;
    logic         oe;
    mcr_spi_req_t req;
  } mcr_port_state_t;

  mcr_port_state_t q;
  mcr_port_state_t next_q;
  logic            fall;
  logic            rise;
  logic [7:0]      cmd_byte;

  assign fall = q.sclk_d & ~q.sclk_s2;
  assign rise = ~q.sclk_d & q.sclk_s2;
  assign cmd_byte = {q.in_sh[6:0], q.din_s2};

  always_comb begin
    next_q = q;
    next_q.sclk_s1 = spi_sclk;
    next_q.sclk_s2 = q.sclk_s1;
    next_q.sclk_d = q.sclk_s2;
    next_q.din_s1 = spi_din;
    next_q.din_s2 = q.din_s1;
    next_q.cs_s1 = spi_cs_n;
    next_q.cs_s2 = q.cs_s1;
    next_q.req.cmd_valid = 1'b0;
    next_q.req.wr_valid = 1'b0;
    if (q.cs_s2) begin
      next_q.phase = MCR_CMD;
      next_q.cnt = 5'h00;
      next_q.oe = 1'b0;
    end else begin
      case (q.phase)
        MCR_CMD: if (fall) begin
          next_q.in_sh = {q.in_sh[14:0], q.din_s2};
          next_q.cnt = q.cnt + 5'h01;
          if (q.cnt == CMD_BITS - 5'h01) begin
            next_q.req.cmd_valid = 1'b1;
            next_q.req.write = cmd_byte[CMD_WRITE_BIT];
            next_q.req.addr = cmd_byte[6:0];
            next_q.last = mcr_end_count(cmd_byte[6:0]);
            next_q.phase = MCR_LOAD;
          end
        end
        MCR_LOAD: begin
          // Read word is left-justified so MSB leaves first
          next_q.out_sh = (q.last == END_SHORT) ?
                          {rd_data[7:0], 8'h00} : rd_data;
          next_q.in_sh = 16'h0000;
          next_q.phase = MCR_DATA;
        end
        MCR_DATA: begin
          if (rise && !q.req.write) begin
            next_q.dout = q.out_sh[15];
            next_q.out_sh = {q.out_sh[14:0], 1'b0};
            next_q.oe = 1'b1;
          end
          if (fall) begin
            next_q.in_sh = {q.in_sh[14:0], q.din_s2};
            next_q.cnt = q.cnt + 5'h01;
            if (q.cnt == q.last - 5'h01) begin
              next_q.req.wr_valid = q.req.write;
              next_q.req.wr_data = {q.in_sh[14:0], q.din_s2};
              next_q.phase = MCR_DONE;
            end
          end
        end
        MCR_DONE: next_q.phase = MCR_DONE;
        default: next_q.phase = MCR_CMD;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.cs_s1 <= 1'b1;
      q.cs_s2 <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign spi_dout = q.dout;
  assign spi_dout_oe = q.oe;
  assign req = q.req;
endmodule

// ---- src/mcr_cal_regs.sv ----
// Calibration register bank with pulse output scaling and serial access
`timescale 1ns/1ps
// Behaviour
// - Three signed 7-bit phase trims, reset zero
// - 13-bit active numerator scales active pulse output
// - 12-bit active denominator, resets to 0x3F
// - Active numerator bits 15:13 flag reverse A,B,C
// - 13-bit reactive numerator scales reactive pulse output
// - Reactive numerator bits 15:13 flag reverse A,B,C
// - 12-bit reactive denominator, resets to 0x3F
// - Read-only count of ones in last read of any other address
// - 12-bit phase C current rms offset, reset zero
// - Three 12-bit active offsets, reset zero
// - Three 12-bit reactive offsets, reset zero
// - Three 8-bit energy dividers, reset zero
// - Read-write registers writable, read-only ones unchanged
module mcr_cal_regs
  import mcr_pkg::*;
#(
  // Arbitrary value
  parameter logic [7:0] DIE_REVISION = 8'h01
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        spi_sclk,
  input  wire logic        spi_din,
  input  wire logic        spi_cs_n,
  output logic             spi_dout,
  output logic             spi_dout_oe,
  input  wire logic        active_energy_tick,
  input  wire logic        reactive_energy_tick,
  input  wire logic [2:0]  active_reverse,
  input  wire logic [2:0]  reactive_reverse,
  output logic             active_pulse_out,
  output logic             reactive_pulse_out,
  output mcr_cal_t         cal
);
  localparam int NUM_W = 13;
  localparam int ACC_W = 15;

  typedef struct packed {
    mcr_cal_t                  cal;
    logic [7:0]                ones;
    logic [1:0][ACC_W-1:0]     acc;
    logic [1:0]                pulse;
  } mcr_bank_state_t;

  mcr_bank_state_t         q;
  mcr_bank_state_t         next_q;
  mcr_spi_req_t            req;
  logic [15:0]             rd_word;
  logic [7:0]              rd_ones;
  logic [15:0]             d;
  logic [1:0][NUM_W-1:0]   num;
  logic [1:0][11:0]        den;
  logic [1:0]              tick;
  logic                    rd_cmd;

  // One write strobe per writable register, index 0 is phase A
  typedef struct packed {
    logic       irms_os_c;
    logic [2:0] active_os;
    logic [2:0] reactive_os;
    logic [2:0] phase_trim;
    logic       active_div;
    logic       reactive_div;
    logic       apparent_div;
    logic       active_num;
    logic       active_den;
    logic       reactive_num;
    logic       reactive_den;
  } mcr_wr_hit_t;

  mcr_wr_hit_t             wr_hit;

  mcr_spi_port u_port (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .spi_sclk    (spi_sclk),
    .spi_din     (spi_din),
    .spi_cs_n    (spi_cs_n),
    .rd_data     (rd_word),
    .spi_dout    (spi_dout),
    .spi_dout_oe (spi_dout_oe),
    .req         (req)
  );

  mcr_ones_count #(
    .W (16)
  ) u_ones (
    .value (rd_word),
    .count (rd_ones)
  );

  assign d = req.wr_data;
  // A read command of any address but the ones count latches the ones count of the word about to shift out
  assign rd_cmd = req.cmd_valid && !req.write;

  // Write decode; read-only and unassigned addresses raise no strobe
  always_comb begin
    wr_hit = '0;
    if (req.wr_valid) begin
      case (req.addr)
        ADDR_IRMS_OS_C: begin
          wr_hit.irms_os_c = 1'b1;
        end

        ADDR_ACT_OS_A: begin
          wr_hit.active_os[0] = 1'b1;
        end
        ADDR_ACT_OS_B: begin
          wr_hit.active_os[1] = 1'b1;
        end
        ADDR_ACT_OS_C: begin
          wr_hit.active_os[2] = 1'b1;
        end
        ADDR_REACT_OS_A: begin
          wr_hit.reactive_os[0] = 1'b1;
        end
        ADDR_REACT_OS_B: begin
          wr_hit.reactive_os[1] = 1'b1;
        end
        ADDR_REACT_OS_C: begin
          wr_hit.reactive_os[2] = 1'b1;
        end

        ADDR_TRIM_A: begin
          wr_hit.phase_trim[0] = 1'b1;
        end
        ADDR_TRIM_B: begin
          wr_hit.phase_trim[1] = 1'b1;
        end
        ADDR_TRIM_C: begin
          wr_hit.phase_trim[2] = 1'b1;
        end

        ADDR_ACT_DIV: begin
          wr_hit.active_div = 1'b1;
        end
        ADDR_REACT_DIV: begin
          wr_hit.reactive_div = 1'b1;
        end
        ADDR_APP_DIV: begin
          wr_hit.apparent_div = 1'b1;
        end

        ADDR_ACT_NUM: begin
          wr_hit.active_num = 1'b1;
        end
        ADDR_ACT_DEN: begin
          wr_hit.active_den = 1'b1;
        end
        ADDR_REACT_NUM: begin
          wr_hit.reactive_num = 1'b1;
        end
        ADDR_REACT_DEN: begin
          wr_hit.reactive_den = 1'b1;
        end
        default: begin
          wr_hit = '0;
        end
      endcase
    end
  end

  // Read multiplexer; narrow values sit in the low bits
  always_comb begin
    rd_word = 16'h0000;
    case (req.addr)
      ADDR_IRMS_OS_C: begin
        rd_word = {4'h0, q.cal.irms_os_c};
      end

      ADDR_ACT_OS_A: begin
        rd_word = {4'h0, q.cal.active_os[0]};
      end
      ADDR_ACT_OS_B: begin
        rd_word = {4'h0, q.cal.active_os[1]};
      end
      ADDR_ACT_OS_C: begin
        rd_word = {4'h0, q.cal.active_os[2]};
      end
      ADDR_REACT_OS_A: begin
        rd_word = {4'h0, q.cal.reactive_os[0]};
      end
      ADDR_REACT_OS_B: begin
        rd_word = {4'h0, q.cal.reactive_os[1]};
      end
      ADDR_REACT_OS_C: begin
        rd_word = {4'h0, q.cal.reactive_os[2]};
      end

      ADDR_TRIM_A: begin
        rd_word = {9'h000, q.cal.phase_trim[0]};
      end
      ADDR_TRIM_B: begin
        rd_word = {9'h000, q.cal.phase_trim[1]};
      end
      ADDR_TRIM_C: begin
        rd_word = {9'h000, q.cal.phase_trim[2]};
      end

      ADDR_ACT_DIV: begin
        rd_word = {8'h00, q.cal.active_div};
      end
      ADDR_REACT_DIV: begin
        rd_word = {8'h00, q.cal.reactive_div};
      end
      ADDR_APP_DIV: begin
        rd_word = {8'h00, q.cal.apparent_div};
      end

      // Top bits show live reverse flags, A at bit 15
      ADDR_ACT_NUM: begin
        rd_word = {active_reverse, q.cal.active_num};
      end
      ADDR_ACT_DEN: begin
        rd_word = {4'h0, q.cal.active_den};
      end
      ADDR_REACT_NUM: begin
        rd_word = {reactive_reverse, q.cal.reactive_num};
      end
      ADDR_REACT_DEN: begin
        rd_word = {4'h0, q.cal.reactive_den};
      end

      ADDR_ONES_COUNT: begin
        rd_word = {8'h00, q.ones};
      end
      ADDR_DIE_REVISION: begin
        rd_word = {8'h00, DIE_REVISION};
      end
      default: begin
        rd_word = 16'h0000;
      end
    endcase
  end

  assign num = {q.cal.reactive_num, q.cal.active_num};
  assign den = {q.cal.reactive_den, q.cal.active_den};
  assign tick = {reactive_energy_tick, active_energy_tick};

  always_comb begin
    logic [ACC_W-1:0] step;
    logic [ACC_W-1:0] sum;
    logic [ACC_W-1:0] lim;
    step = '0;
    sum = '0;
    lim = '0;
    next_q = q;

    // Host writes, one strobe per register
    if (wr_hit.irms_os_c) begin
      next_q.cal.irms_os_c = d[11:0];
    end

    for (int p = 0; p < 3; p++) begin
      if (wr_hit.active_os[p]) begin
        next_q.cal.active_os[p] = d[11:0];
      end
      if (wr_hit.reactive_os[p]) begin
        next_q.cal.reactive_os[p] = d[11:0];
      end
      if (wr_hit.phase_trim[p]) begin
        next_q.cal.phase_trim[p] = d[6:0];
      end
    end

    if (wr_hit.active_div) begin
      next_q.cal.active_div = d[7:0];
    end

    if (wr_hit.reactive_div) begin
      next_q.cal.reactive_div = d[7:0];
    end

    if (wr_hit.apparent_div) begin
      next_q.cal.apparent_div = d[7:0];
    end

    // Flag bits are hardware state, so only 12:0 are kept
    if (wr_hit.active_num) begin
      next_q.cal.active_num = d[REV_FLAG_LSB-1:0];
    end

    if (wr_hit.active_den) begin
      next_q.cal.active_den = d[11:0];
    end

    if (wr_hit.reactive_num) begin
      next_q.cal.reactive_num = d[REV_FLAG_LSB-1:0];
    end

    if (wr_hit.reactive_den) begin
      next_q.cal.reactive_den = d[11:0];
    end

    // Ones count of every read except of itself
    if (rd_cmd && req.addr != ADDR_ONES_COUNT) begin
      next_q.ones = rd_ones;
    end

    // Pulse rate = tick rate * (num + 1) / (den + 1)
    for (int k = 0; k < 2; k++) begin
      step = tick[k] ? ACC_W'(num[k]) + ACC_W'(1) : '0;
      sum = q.acc[k] + step;
      // Saturate rather than wrap on a dense tick burst
      if (sum < q.acc[k]) begin
        sum = '1;
      end
      lim = ACC_W'(den[k]) + ACC_W'(1);
      if (sum >= lim) begin
        next_q.acc[k] = sum - lim;
        next_q.pulse[k] = 1'b1;
      end else begin
        next_q.acc[k] = sum;
        next_q.pulse[k] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q.cal.irms_os_c <= OFFSET_RST;
      q.cal.active_os <= {3{OFFSET_RST}};
      q.cal.reactive_os <= {3{OFFSET_RST}};
      q.cal.phase_trim <= {3{TRIM_RST}};
      q.cal.active_div <= DIV_RST;
      q.cal.reactive_div <= DIV_RST;
      q.cal.apparent_div <= DIV_RST;
      q.cal.active_num <= NUM_RST;
      q.cal.active_den <= DEN_RST;
      q.cal.reactive_num <= NUM_RST;
      q.cal.reactive_den <= DEN_RST;
      q.ones <= ONES_RST;
      q.acc <= '0;
      q.pulse <= 2'b00;
    end else begin
      q <= next_q;
    end
  end

  assign cal = q.cal;
  assign active_pulse_out = q.pulse[0];
  assign reactive_pulse_out = q.pulse[1];
endmodule

// ---- verification/mcr_cal_regs_chk.sv ----
// Port-level assertions for the calibration bank
`timescale 1ns/1ps
module mcr_cal_regs_chk
  import mcr_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       spi_sclk,
  input wire logic       spi_din,
  input wire logic       spi_cs_n,
  input wire logic       spi_dout,
  input wire logic       spi_dout_oe,
  input wire logic       active_energy_tick,
  input wire logic       reactive_energy_tick,
  input wire logic [2:0] active_reverse,
  input wire logic [2:0] reactive_reverse,
  input wire logic       active_pulse_out,
  input wire logic       reactive_pulse_out,
  input wire mcr_cal_t   cal
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_rst_values: assert property (
    $rose(rst_n) |-> cal.active_den == DEN_RST &&
      cal.reactive_den == DEN_RST && cal.active_num == NUM_RST
  ) else $error("denominator or numerator reset value wrong");
  chk_rst_quiet: assert property (
    $rose(rst_n) |-> !spi_dout_oe && !active_pulse_out &&
      !reactive_pulse_out
  ) else $error("outputs not idle after reset");
  chk_act_pulse_cause: assert property (
    active_pulse_out && $stable(cal.active_den) |->
      $past(active_energy_tick) || $past(active_energy_tick, 2) ||
      $past(active_pulse_out)
  ) else $error("active pulse without a tick");
  chk_react_pulse_cause: assert property (
    reactive_pulse_out && $stable(cal.reactive_den) |->
      $past(reactive_energy_tick) || $past(reactive_energy_tick, 2) ||
      $past(reactive_pulse_out)
  ) else $error("reactive pulse without a tick");
  chk_oe_idle: assert property (
    spi_cs_n [*5] |-> !spi_dout_oe
  ) else $error("data out driven while deselected");
  chk_oe_select: assert property (
    $rose(spi_dout_oe) |-> !$past(spi_cs_n, 3)
  ) else $error("data out enabled without select");
  chk_dout_hold: assert property (
    (spi_dout_oe && !spi_sclk) [*6] |-> $stable(spi_dout)
  ) else $error("data out moved while clock low");
  chk_cal_quiet: assert property (
    spi_cs_n [*8] |-> $stable(cal)
  ) else $error("register changed with no transfer");
endmodule

bind mcr_cal_regs mcr_cal_regs_chk u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .spi_sclk(spi_sclk),
  .spi_din(spi_din), .spi_cs_n(spi_cs_n), .spi_dout(spi_dout),
  .spi_dout_oe(spi_dout_oe), .active_energy_tick(active_energy_tick),
  .reactive_energy_tick(reactive_energy_tick),
  .active_reverse(active_reverse), .reactive_reverse(reactive_reverse),
  .active_pulse_out(active_pulse_out),
  .reactive_pulse_out(reactive_pulse_out), .cal(cal)
);

// ---- verification/mcr_host_model.sv ----
// Host controller model driving the serial port
`timescale 1ns/1ps
module mcr_host_model (
  input  wire logic clk_sys,
  output logic      spi_sclk,
  output logic      spi_din,
  output logic      spi_cs_n,
  input  wire logic spi_dout
);
  initial begin
    spi_sclk = 1'b0;
    spi_din  = 1'b0;
    spi_cs_n = 1'b1;
  end

  task automatic half();
    repeat (10) @(negedge clk_sys);
  endtask

  // Command byte then nd data bits, MSB first; sampled on falling sclk
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd,
                      input int nd, output logic [15:0] rd);
    logic [23:0] sh;
    sh = {cmd, wd << (16 - nd)};
    rd = 16'h0000;
    spi_cs_n <= 1'b0;
    half();
    for (int i = 0; i < 8 + nd; i++) begin
      spi_din  <= sh[23 - i];
      spi_sclk <= 1'b1;
      half();
      if (i >= 8) rd = {rd[14:0], spi_dout};
      spi_sclk <= 1'b0;
      half();
    end
    spi_cs_n <= 1'b1;
    // Released line floats away from its last level
    spi_din  <= ~spi_din;
    half();
  endtask
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the calibration bank
`timescale 1ns/1ps
module tb_top;
  import mcr_pkg::*;
  // Arbitrary value
  localparam logic [7:0] REV = 8'h5A;
  logic        clk_sys, rst_n, spi_sclk, spi_din, spi_cs_n;
  logic        spi_dout, spi_dout_oe, act_tick, react_tick;
  logic        act_pulse, react_pulse;
  logic [2:0]  act_rev, react_rev;
  mcr_cal_t    cal;
  logic [15:0] rd, e, n_ap, n_rp;
  int          n_errors = 0;
  int          compares = 0;

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  mcr_cal_regs #(.DIE_REVISION(REV)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .spi_sclk(spi_sclk),
    .spi_din(spi_din), .spi_cs_n(spi_cs_n), .spi_dout(spi_dout),
    .spi_dout_oe(spi_dout_oe), .active_energy_tick(act_tick),
    .reactive_energy_tick(react_tick), .active_reverse(act_rev),
    .reactive_reverse(react_rev), .active_pulse_out(act_pulse),
    .reactive_pulse_out(react_pulse), .cal(cal));
  mcr_host_model host (
    .clk_sys(clk_sys), .spi_sclk(spi_sclk), .spi_din(spi_din),
    .spi_cs_n(spi_cs_n), .spi_dout(spi_dout));

  always @(posedge clk_sys) begin
    if (act_pulse === 1'b1) n_ap <= n_ap + 16'h0001;
    if (react_pulse === 1'b1) n_rp <= n_rp + 16'h0001;
  end

  function automatic bit wide(input logic [6:0] a);
    return (a >= 7'h38 && a <= 7'h3E) || (a >= 7'h45 && a <= 7'h48);
  endfunction
  function automatic logic [15:0] msk(input logic [6:0] a);
    if (a == 7'h45 || a == 7'h47) return 16'h1FFF;
    if (wide(a)) return 16'h0FFF;
    if (a <= 7'h41) return 16'h007F;
    return 16'h00FF;
  endfunction
  function automatic logic [15:0] pat(input logic [6:0] a);
    return 16'hB6D5 ^ {9'h000, a};
  endfunction

  task automatic cmp(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd_reg(input logic [6:0] a, output logic [15:0] v);
    host.xfer({1'b0, a}, 16'h0000, wide(a) ? 16 : 8, v);
  endtask
  task automatic wr_reg(input logic [6:0] a, input logic [15:0] v);
    logic [15:0] junk;
    host.xfer({1'b1, a}, v, wide(a) ? 16 : 8, junk);
  endtask

  task automatic t_reset();
    for (logic [6:0] a = 7'h38; a <= 7'h48; a++) begin
      e = (a == 7'h46 || a == 7'h48) ? 16'h003F : 16'h0000;
      rd_reg(a, rd);
      cmp("reset value", e, rd);
    end
    $display("t_reset done");
  endtask

  task automatic t_rw();
    for (logic [6:0] a = 7'h38; a <= 7'h48; a++) wr_reg(a, pat(a));
    for (logic [6:0] a = 7'h38; a <= 7'h48; a++) begin
      rd_reg(a, rd);
      cmp("readback", pat(a) & msk(a), rd);
    end
    $display("t_rw done");
  endtask

  task automatic t_access();
    act_rev = 3'b100;
    react_rev = 3'b011;
    rd_reg(ADDR_ACT_NUM, rd);
    cmp("act num", 16'h8000 | (pat(7'h45) & 16'h1FFF), rd);
    e = 16'h6000 | (pat(7'h47) & 16'h1FFF);
    rd_reg(ADDR_REACT_NUM, rd);
    cmp("react num", e, rd);
    rd_reg(ADDR_ONES_COUNT, rd);
    cmp("ones count", 16'($countones(e)), rd);
    wr_reg(ADDR_DIE_REVISION, 16'h00A3);
    wr_reg(ADDR_ONES_COUNT, 16'h00A3);
    wr_reg(7'h50, 16'h00FF);
    rd_reg(ADDR_ONES_COUNT, rd);
    cmp("ones after writes", 16'($countones(e)), rd);
    rd_reg(ADDR_DIE_REVISION, rd);
    cmp("revision", {8'h00, REV}, rd);
    rd_reg(ADDR_ONES_COUNT, rd);
    cmp("ones count", 16'($countones(REV)), rd);
    rd_reg(7'h50, rd);
    cmp("unmapped", 16'h0000, rd);
    act_rev = 3'b000;
    react_rev = 3'b000;
    $display("t_access done");
  endtask

  task automatic t_pulse();
    wr_reg(ADDR_ACT_NUM, 16'h0001);
    wr_reg(ADDR_ACT_DEN, 16'h0003);
    wr_reg(ADDR_REACT_NUM, 16'h0001);
    wr_reg(ADDR_REACT_DEN, 16'h0003);
    cmp("cal den", 16'h0003, {4'h0, cal.active_den});
    cmp("cal react den", 16'h0003, {4'h0, cal.reactive_den});
    n_ap = 16'h0000;
    n_rp = 16'h0000;
    repeat (20) begin
      act_tick = 1'b1;
      react_tick = 1'b1;
      @(negedge clk_sys);
      act_tick = 1'b0;
      react_tick = 1'b0;
      repeat (5) @(negedge clk_sys);
    end
    cmp("act pulses", 16'h000A, n_ap);
    cmp("react pulses", 16'h000A, n_rp);
    $display("t_pulse done");
  endtask

  task automatic final_report();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #1_000_000;
    n_errors++;
    final_report();
  end

  initial begin
    rst_n = 1'b0;
    act_tick = 1'b0;
    react_tick = 1'b0;
    act_rev = 3'b000;
    react_rev = 3'b000;
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    t_reset();
    t_rw();
    t_access();
    t_pulse();
    final_report();
  end
endmodule
